/* shexp_pkg.sv */
package shexp_pkg;
  // clock and time base
  localparam int CLK_PS = 4000;
  localparam int BASE_SER_PS = 16129;
  localparam int BASE_PAR_PS = 64516;
  localparam int BASE_SER_CYC = (BASE_SER_PS + CLK_PS - 1) / CLK_PS;
  localparam int BASE_PAR_CYC = (BASE_PAR_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRIG_MIN_NS = 100;
  localparam int TRIG_MIN_CYC = (TRIG_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int FOT_CYCLES = 64;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FRAME_LEN = 8'h04;
  localparam logic [7:0] ADDR_EXPOSURE = 8'h08;
  localparam logic [7:0] ADDR_RESET_HOLD = 8'h0C;
  localparam logic [7:0] ADDR_PRESCALE = 8'h10;
  localparam logic [7:0] ADDR_PADDING = 8'h14;
  localparam logic [7:0] ADDR_ACTIVE = 8'h18;
  localparam logic [7:0] ADDR_LINE_LEN = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FTS_BIT = 2;
  localparam int CTRL_EN_BIT = 3;
  localparam int CTRL_CHOOSER_LSB = 4;
  // reset values and first-line chooser code
  localparam logic [15:0] RST_FRAME_LEN = 16'h0400;
  localparam logic [15:0] RST_EXPOSURE = 16'h0100;
  localparam logic [15:0] RST_RESET_HOLD = 16'h0010;
  localparam logic [15:0] RST_PRESCALE = 16'h0001;
  localparam logic [15:0] RST_PADDING = 16'h0000;
  localparam logic [15:0] RST_ACTIVE = 16'h0010;
  localparam logic [15:0] RST_LINE_LEN = 16'h0080;
  localparam logic [3:0] CHOOSE_FIRST_LINE = 4'h5;
  // shutter modes
  typedef enum logic [1:0] {
    MODE_PIPE = 2'h0,
    MODE_TRIG = 2'h1,
    MODE_SLAVE = 2'h2,
    MODE_ROLL = 2'h3
  } shexp_mode_t;
  // global shutter sequence states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_FOT = 7'h02,
    ST_RST = 7'h04,
    ST_ARM = 7'h08,
    ST_WLINE = 7'h10,
    ST_EXP = 7'h20,
    ST_EXT = 7'h40
  } shexp_state_t;
  // pixel array controls
  typedef struct packed {
    logic photodiode_reset;
    logic exposing;
    logic storage_xfer;
    logic line_valid;
    logic padding_row;
  } shexp_seq_t;
endpackage : shexp_pkg

/* shexp_tick_gen.sv */
`timescale 1ns/1ps
module shexp_tick_gen #(
  parameter int BASE_CYC = shexp_pkg::BASE_SER_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic restart,
  input wire logic [15:0] prescale,
  // prescaled tick
  output logic tick
);
  import shexp_pkg::*;
  logic [7:0] bcnt_ff;
  logic [15:0] pcnt_ff;
  logic tick_ff;
  logic [15:0] pre_m1;
  logic base_last;

  // a prescale of zero behaves as one
  assign pre_m1 = (prescale == 16'h0000) ? 16'h0000 : prescale - 16'h0001;
  assign base_last = (bcnt_ff == 8'(BASE_CYC - 1));
  assign tick = tick_ff;

  // base unit counter, then prescale counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_ff <= 8'h00;
      pcnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (restart) begin
      bcnt_ff <= 8'h00;
      pcnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (base_last) begin
        bcnt_ff <= 8'h00;
        if (pcnt_ff >= pre_m1) begin
          pcnt_ff <= 16'h0000;
          tick_ff <= 1'b1; // RQ2
        end else begin
          pcnt_ff <= pcnt_ff + 16'h0001;
        end
      end else begin
        bcnt_ff <= bcnt_ff + 8'h01;
      end
    end
  end

  // a tick is never followed directly by another one
  property p_tick_gap;
    @(posedge pclk) disable iff (!presetn) tick_ff |=> !tick_ff;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick repeated"); // RQ2
endmodule : shexp_tick_gen

/* shexp_trig_sync.sv */
`timescale 1ns/1ps
module shexp_trig_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // trigger pin
  input wire logic pin,
  // synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic rise_ff;
  logic fall_ff;

  // two-flop synchroniser, third flop for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      s1_ff <= pin; // RQ19
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      rise_ff <= s2_ff & ~s3_ff; // RQ19
      fall_ff <= ~s2_ff & s3_ff;
    end
  end

  assign level = s3_ff;
  assign rise = rise_ff;
  assign fall = fall_ff;

  // edges are single pulses
  property p_rise_pulse;
    @(posedge pclk) disable iff (!presetn) rise_ff |=> !rise_ff && !fall_ff;
  endproperty
  a_rise_pulse: assert property (p_rise_pulse) else $error("rise pulse too long"); // RQ19
endmodule : shexp_trig_sync

/* shexp_sequencer.sv */
// Function
// RQ1: pipelined global master timing comes from 16-bit frame length and exposure.
// RQ2: reset hold and exposure counts scale by prescale of base system-clock units.
// RQ3: storage transfer happens in the transfer interval, then all photodiodes reset.
// RQ4: global reset held reset_hold times prescale; release starts exposure.
// RQ5: timer-driven exposure lasts exposure register times prescale.
// RQ6: exposure starting during readout waits for next line start; reset prolonged.
// RQ7: exposure extended until every active line is read out.
// RQ8: frame-time select derives reset duration from frame length minus exposure.
// RQ9: triggered master starts exposure on trigger rise, timed by exposure and prescale.
// RQ10: triggered master ignores trigger fall; controller holds trigger 100 ns.
// RQ11: triggered master extends exposure until last active line is read.
// RQ12: controller keeps trigger low during the transfer interval.
// RQ13: chooser 0x5 flags the first line on status pin; new trigger after it.
// RQ14: slave mode: rise starts exposure, fall starts transfer and readout.
// RQ15: slave mode extends exposure if trigger falls before readout completes.
// RQ16: rolling exposure is a whole number of line times from exposure register.
// RQ17: rolling exposure limited to frame time; padding rows carry no data.
// RQ18: padding row count per rolling frame comes from padding register.
// RQ19: trigger synchronised to system clock and edge-detected before use.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module shexp_sequencer #(
  parameter bit PARALLEL_VARIANT = 1'b0,
  parameter int FOT_CYC = shexp_pkg::FOT_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // controller pins
  input wire logic exposure_trigger_pin,
  output logic status_out_pin_a,
  // pixel array controls
  output shexp_pkg::shexp_seq_t seq_out,
  output logic [15:0] row_addr,
  output logic [15:0] roll_reset_row
);
  import shexp_pkg::*;
  localparam int BASE_CYC = PARALLEL_VARIANT ? BASE_PAR_CYC : BASE_SER_CYC;

  shexp_mode_t mode_ff;
  logic fts_ff;
  logic enable_ff;
  logic [3:0] chooser_ff;
  logic [15:0] frame_len_ff;
  logic [15:0] exposure_ff;
  logic [15:0] reset_hold_ff;
  logic [15:0] prescale_ff;
  logic [15:0] padding_ff;
  logic [15:0] active_ff;
  logic [15:0] line_len_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  shexp_state_t st_ff;
  shexp_state_t nxt_st;
  shexp_state_t exp_entry;
  logic [15:0] ucnt_ff;
  logic tick;
  logic trig_lvl;
  logic trig_rise;
  logic trig_fall;
  logic rd_active_ff;
  logic [15:0] row_ff;
  logic [15:0] lcnt_ff;
  logic [15:0] line_m1;
  logic [16:0] frame_rows;
  logic [16:0] rows_m1;
  logic [16:0] exp_lines;
  logic [16:0] rst_sum;
  logic [16:0] rst_row;
  logic line_start;
  logic line_end;
  logic rd_start;
  logic fot_done;
  logic [15:0] rst_target;
  logic rst_done;
  logic exp_done;
  logic roll;
  shexp_seq_t seq_ff;
  logic status_ff;
  logic [15:0] row_addr_ff;
  logic [15:0] roll_row_ff;

  // offsets answered by the register file
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= ADDR_STATUS) && (a[1:0] == 2'b00);
  endfunction : mapped

  assign roll = (mode_ff == MODE_ROLL);

  // apb handshake: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~mapped(paddr);
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL: prdata_ff <= {24'h000000, chooser_ff, enable_ff, fts_ff, mode_ff};
        ADDR_FRAME_LEN: prdata_ff <= {16'h0000, frame_len_ff};
        ADDR_EXPOSURE: prdata_ff <= {16'h0000, exposure_ff};
        ADDR_RESET_HOLD: prdata_ff <= {16'h0000, reset_hold_ff};
        ADDR_PRESCALE: prdata_ff <= {16'h0000, prescale_ff};
        ADDR_PADDING: prdata_ff <= {16'h0000, padding_ff};
        ADDR_ACTIVE: prdata_ff <= {16'h0000, active_ff};
        ADDR_LINE_LEN: prdata_ff <= {16'h0000, line_len_ff};
        ADDR_STATUS: prdata_ff <= {row_ff, 7'h00, trig_lvl, rd_active_ff, st_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // configuration registers, written at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= MODE_PIPE;
      fts_ff <= 1'b0;
      enable_ff <= 1'b0;
      chooser_ff <= 4'h0;
      frame_len_ff <= RST_FRAME_LEN;
      exposure_ff <= RST_EXPOSURE;
      reset_hold_ff <= RST_RESET_HOLD;
      prescale_ff <= RST_PRESCALE;
      padding_ff <= RST_PADDING;
      active_ff <= RST_ACTIVE;
      line_len_ff <= RST_LINE_LEN;
    end else if (psel && penable && pready_ff && pwrite) begin
      case (paddr)
        ADDR_CTRL: begin
          mode_ff <= shexp_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
          fts_ff <= pwdata[CTRL_FTS_BIT];
          enable_ff <= pwdata[CTRL_EN_BIT];
          chooser_ff <= pwdata[CTRL_CHOOSER_LSB +: 4];
        end
        ADDR_FRAME_LEN: frame_len_ff <= pwdata[15:0]; // RQ1
        ADDR_EXPOSURE: exposure_ff <= pwdata[15:0]; // RQ1
        ADDR_RESET_HOLD: reset_hold_ff <= pwdata[15:0];
        ADDR_PRESCALE: prescale_ff <= pwdata[15:0];
        ADDR_PADDING: padding_ff <= pwdata[15:0]; // RQ18
        ADDR_ACTIVE: active_ff <= pwdata[15:0];
        ADDR_LINE_LEN: line_len_ff <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // prescaled time base, restarted on every state change
  shexp_tick_gen #(.BASE_CYC(BASE_CYC)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .restart(nxt_st != st_ff),
    .prescale(prescale_ff),
    .tick(tick)
  );

  // trigger pin brought into the clock domain
  shexp_trig_sync u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .pin(exposure_trigger_pin),
    .level(trig_lvl),
    .rise(trig_rise),
    .fall(trig_fall)
  );

  // line and frame geometry; padding rows only in rolling mode
  assign line_m1 = (line_len_ff == 16'h0000) ? 16'h0000 : line_len_ff - 16'h0001;
  assign frame_rows = {1'b0, active_ff} + (roll ? {1'b0, padding_ff} : 17'h00000); // RQ17 RQ18
  assign rows_m1 = (frame_rows == 17'h00000) ? 17'h00000 : frame_rows - 17'h00001;
  assign line_start = rd_active_ff && (lcnt_ff == 16'h0000);
  assign line_end = rd_active_ff && (lcnt_ff == line_m1);
  assign fot_done = (st_ff == ST_FOT) && (ucnt_ff == 16'(FOT_CYC - 1));
  assign rd_start = fot_done || (roll && enable_ff && !rd_active_ff);

  // readout engine: one row per line time, start of line is the overhead slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_active_ff <= 1'b0;
      row_ff <= 16'h0000;
      lcnt_ff <= 16'h0000;
    end else if (rd_start) begin
      rd_active_ff <= 1'b1;
      row_ff <= 16'h0000;
      lcnt_ff <= 16'h0000;
    end else if (rd_active_ff) begin
      if (line_end) begin
        lcnt_ff <= 16'h0000;
        if ({1'b0, row_ff} >= rows_m1) begin
          rd_active_ff <= 1'b0;
        end else begin
          row_ff <= row_ff + 16'h0001;
        end
      end else begin
        lcnt_ff <= lcnt_ff + 16'h0001;
      end
    end
  end

  // reset duration, either direct or derived from frame time
  always_comb begin
    rst_target = reset_hold_ff; // RQ4
    if (fts_ff) begin
      rst_target = (frame_len_ff > exposure_ff) ? frame_len_ff - exposure_ff : 16'h0000; // RQ8
    end
  end

  assign rst_done = (ucnt_ff >= rst_target); // RQ2
  assign exp_done = (ucnt_ff >= exposure_ff); // RQ5
  assign exp_entry = (rd_active_ff && !line_start) ? ST_WLINE : ST_EXP; // RQ6

  // global shutter sequence
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (mode_ff == MODE_PIPE) begin
          nxt_st = ST_FOT;
        end else begin
          nxt_st = ST_ARM;
        end
      end
      ST_FOT: begin
        if (fot_done) begin
          nxt_st = (mode_ff == MODE_PIPE) ? ST_RST : ST_ARM; // RQ3
        end
      end
      ST_RST: begin
        if (rst_done) begin
          nxt_st = exp_entry; // RQ4
        end
      end
      ST_ARM: begin
        if (trig_rise) begin
          nxt_st = exp_entry; // RQ9 RQ14
        end
      end
      ST_WLINE: begin
        if (line_start || !rd_active_ff) begin
          nxt_st = ST_EXP; // RQ6
        end
      end
      ST_EXP: begin
        if (mode_ff == MODE_SLAVE) begin
          if (trig_fall) begin
            nxt_st = rd_active_ff ? ST_EXT : ST_FOT; // RQ14 RQ15
          end
        end else if (exp_done) begin // RQ10
          nxt_st = rd_active_ff ? ST_EXT : ST_FOT; // RQ7 RQ11
        end
      end
      ST_EXT: begin
        if (!rd_active_ff) begin
          nxt_st = ST_FOT; // RQ7
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    if (!enable_ff || roll) begin
      nxt_st = ST_IDLE;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // unit counter: cycles in transfer, prescaled ticks elsewhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ucnt_ff <= 16'h0000;
    end else if (nxt_st != st_ff) begin
      ucnt_ff <= 16'h0000;
    end else if ((tick || st_ff == ST_FOT) && ucnt_ff != 16'hFFFF) begin
      ucnt_ff <= ucnt_ff + 16'h0001; // RQ2
    end
  end

  // rolling reset pointer leads the read row by the exposure in lines
  assign exp_lines = ({1'b0, exposure_ff} > frame_rows) ? frame_rows : {1'b0, exposure_ff}; // RQ17
  assign rst_sum = {1'b0, row_ff} + exp_lines; // RQ16
  assign rst_row = (rst_sum >= frame_rows) ? rst_sum - frame_rows : rst_sum;

  // registered array controls and status pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_ff <= '0;
      status_ff <= 1'b0;
      row_addr_ff <= 16'h0000;
      roll_row_ff <= 16'h0000;
    end else begin
      seq_ff.photodiode_reset <= !roll && (nxt_st == ST_IDLE || nxt_st == ST_RST
                                 || nxt_st == ST_ARM || nxt_st == ST_WLINE); // RQ3 RQ6
      seq_ff.exposing <= roll ? enable_ff : (nxt_st == ST_EXP || nxt_st == ST_EXT);
      seq_ff.storage_xfer <= (nxt_st == ST_FOT); // RQ3
      seq_ff.line_valid <= rd_active_ff && (row_ff < active_ff);
      seq_ff.padding_row <= rd_active_ff && (row_ff >= active_ff); // RQ17
      status_ff <= (chooser_ff == CHOOSE_FIRST_LINE) && rd_active_ff && (row_ff == 16'h0000); // RQ13
      row_addr_ff <= row_ff;
      roll_row_ff <= roll ? rst_row[15:0] : 16'h0000; // RQ16
    end
  end

  assign seq_out = seq_ff;
  assign status_out_pin_a = status_ff;
  assign row_addr = row_addr_ff;
  assign roll_reset_row = roll_row_ff;

  // assertions
  property p_fot_to_reset;
    @(posedge pclk) disable iff (!presetn)
      fot_done && enable_ff && !roll |=> seq_ff.photodiode_reset ##0 !seq_ff.storage_xfer;
  endproperty
  a_fot_to_reset: assert property (p_fot_to_reset) else $error("no reset after transfer"); // RQ3

  property p_reset_hold;
    @(posedge pclk) disable iff (!presetn)
      st_ff == ST_RST && !rst_done |=> st_ff == ST_RST || !enable_ff || roll;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset released early"); // RQ4

  property p_exp_timer;
    @(posedge pclk) disable iff (!presetn)
      st_ff == ST_EXP && mode_ff != MODE_SLAVE && !exp_done && enable_ff |=> st_ff == ST_EXP;
  endproperty
  a_exp_timer: assert property (p_exp_timer) else $error("exposure ended early"); // RQ5

  property p_line_sync;
    @(posedge pclk) disable iff (!presetn)
      st_ff == ST_WLINE && rd_active_ff && !line_start && enable_ff |=> st_ff == ST_WLINE;
  endproperty
  a_line_sync: assert property (p_line_sync) else $error("exposure not line aligned"); // RQ6

  property p_extend;
    @(posedge pclk) disable iff (!presetn)
      st_ff == ST_EXT && rd_active_ff && enable_ff |=> seq_ff.exposing && !seq_ff.storage_xfer;
  endproperty
  a_extend: assert property (p_extend) else $error("exposure not extended"); // RQ7

  property p_trig_start;
    @(posedge pclk) disable iff (!presetn)
      st_ff == ST_ARM && trig_rise && enable_ff && !roll |=> st_ff == ST_EXP || st_ff == ST_WLINE;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger rise ignored"); // RQ9

  property p_fall_ignored;
    @(posedge pclk) disable iff (!presetn)
      mode_ff == MODE_TRIG && st_ff == ST_EXP && trig_fall && !exp_done && enable_ff |=> st_ff == ST_EXP;
  endproperty
  a_fall_ignored: assert property (p_fall_ignored) else $error("falling edge acted on"); // RQ10

  property p_slave_fall;
    @(posedge pclk) disable iff (!presetn)
      mode_ff == MODE_SLAVE && st_ff == ST_EXP && trig_fall && enable_ff
      |=> (st_ff == ST_EXT) == $past(rd_active_ff);
  endproperty
  a_slave_fall: assert property (p_slave_fall) else $error("slave fall handled wrongly"); // RQ15

  property p_first_line;
    @(posedge pclk) disable iff (!presetn)
      chooser_ff == CHOOSE_FIRST_LINE && $rose(rd_active_ff) |=> status_ff;
  endproperty
  a_first_line: assert property (p_first_line) else $error("first line not flagged"); // RQ13

  property p_roll_rows;
    @(posedge pclk) disable iff (!presetn)
      roll && rd_active_ff && frame_rows != 17'h00000 |-> {1'b0, row_ff} <= rows_m1;
  endproperty
  a_roll_rows: assert property (p_roll_rows) else $error("row beyond frame"); // RQ18

  // main scenarios
  c_pipe_frame: cover property (@(posedge pclk) disable iff (!presetn)
    mode_ff == MODE_PIPE && st_ff == ST_EXT ##1 st_ff == ST_FOT);
  c_trig_line_wait: cover property (@(posedge pclk) disable iff (!presetn)
    mode_ff == MODE_TRIG && st_ff == ST_WLINE ##1 st_ff == ST_EXP);
  c_slave_extend: cover property (@(posedge pclk) disable iff (!presetn)
    mode_ff == MODE_SLAVE && st_ff == ST_EXT);
  c_roll_padding: cover property (@(posedge pclk) disable iff (!presetn)
    roll && seq_ff.padding_row);
endmodule : shexp_sequencer

/* shexp_ctrl_model.sv */
`timescale 1ns/1ps
module shexp_ctrl_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command from bench
  input wire logic fire,
  input wire logic wait_stat,
  input wire logic [15:0] width,
  // device pins
  input wire logic status_out_pin_a,
  output logic trig,
  output logic busy
);
  import shexp_pkg::*;
  // trigger pulse: optional wait for first-line flag, then a held high level
  initial begin
    trig = 1'b0;
    busy = 1'b0;
  end
  always @(posedge pclk) begin
    logic prev;
    int n;
    if (presetn && fire && !busy) begin
      busy <= 1'b1;
      if (wait_stat) begin
        do begin
          prev = status_out_pin_a;
          @(posedge pclk);
        end while (!(status_out_pin_a && !prev));
      end
      trig <= 1'b1;
      n = (width < TRIG_MIN_CYC) ? TRIG_MIN_CYC : width;
      repeat (n) @(posedge pclk);
      trig <= 1'b0;
      busy <= 1'b0;
    end
  end
endmodule : shexp_ctrl_model

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  import shexp_pkg::*;
  localparam int FRAME_TRANSFER_INTERVAL = 8;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, trig, stat, busy, fire = 1'b0, wait_stat = 1'b0;
  logic [15:0] width = 16'h0, row_addr, roll_reset_row, rnd = 16'hB09A;
  logic [4:0] sq;
  shexp_seq_t seq;
  int n_fail = 0, num_checks = 0;
  assign sq = seq;
  // clock, reset and watchdog
  always #2 pclk = ~pclk;
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  end
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
  shexp_sequencer #(.PARALLEL_VARIANT(1'b0), .FOT_CYC(FRAME_TRANSFER_INTERVAL)) shexp_sequencer_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .exposure_trigger_pin(trig),
    .status_out_pin_a(stat), .seq_out(seq), .row_addr(row_addr), .roll_reset_row(roll_reset_row));
  shexp_ctrl_model shexp_ctrl_model_inst (.pclk(pclk), .presetn(presetn), .fire(fire),
    .wait_stat(wait_stat), .width(width), .status_out_pin_a(stat), .trig(trig), .busy(busy));
  // expectation helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] ctrl(input int m, input int fts, input int ch);
    return 32'((ch << CTRL_CHOOSER_LSB) | (1 << CTRL_EN_BIT) | (fts << CTRL_FTS_BIT) | m);
  endfunction : ctrl
  function automatic logic [15:0] roll_exp(input logic [15:0] row, input int e, input int rows);
    return 16'((int'(row) + ((e < rows) ? e : rows)) % rows);
  endfunction : roll_exp
  task automatic conclude();
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: value %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("Error %0t: span %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : cmp_rng
  // apb master: setup, access held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input int d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, 32'(d), q, e);
  endtask : wr
  task automatic cfg(input int e, input int p, input int r, input int f, input int a, input int l);
    logic [7:0] ad[6];
    int v[6];
    ad = '{ADDR_EXPOSURE, ADDR_PRESCALE, ADDR_RESET_HOLD, ADDR_FRAME_LEN, ADDR_ACTIVE, ADDR_LINE_LEN};
    v = '{e, p, r, f, a, l};
    wr(ADDR_CTRL, 0);
    for (int i = 0; i < 6; i++) wr(ad[i], v[i]);
  endtask : cfg
  task automatic until_v(input int b, input logic v, output int n);
    n = 0;
    while (sq[b] !== v) begin
      @(posedge pclk);
      n++;
    end
  endtask : until_v
  // main sequence
  initial begin
    logic [7:0] ra[7];
    logic [15:0] rv[7];
    logic [31:0] q;
    logic e, ps;
    logic [15:0] pr;
    int n, g, w, ex, er, pd, rs, p, r, f;
    ra = '{ADDR_FRAME_LEN, ADDR_EXPOSURE, ADDR_RESET_HOLD, ADDR_PRESCALE, ADDR_PADDING, ADDR_ACTIVE,
      ADDR_LINE_LEN};
    rv = '{RST_FRAME_LEN, RST_EXPOSURE, RST_RESET_HOLD, RST_PRESCALE, RST_PADDING, RST_ACTIVE, RST_LINE_LEN};
    @(posedge presetn);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra[i], 32'h0, q, e);
      cmp(q, {16'h0, rv[i]});
    end
    apb(1'b1, 8'h24, 32'hFFFF, q, e);
    cmp(e, 1'b1);
    rnd = lfsr(rnd);
    apb(1'b1, ADDR_EXPOSURE, {16'hFFFF, rnd}, q, e);
    apb(1'b0, ADDR_EXPOSURE, 32'h0, q, e);
    cmp(q, {16'h0, rnd});
    // pipelined master: random timers, frame-time select, short-timer corner
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      ex = (i == 3) ? 1 : 2 + rnd[1:0];
      p = (i == 3) ? 1 : 1 + rnd[3:2] % 3;
      r = (i == 3) ? 1 : 2 + rnd[5:4];
      f = ex + r + 1;
      cfg(ex, p, r, f, (i == 3) ? 4 : 2, (i == 3) ? 8 : 4);
      wr(ADDR_CTRL, ctrl(MODE_PIPE, i == 2, 0));
      until_v(2, 1'b1, n);
      until_v(2, 1'b0, n);
      cmp(sq[4], 1'b1);
      cmp_rng(n, FRAME_TRANSFER_INTERVAL, FRAME_TRANSFER_INTERVAL + 1);
      until_v(3, 1'b1, g);
      cmp(sq[4], 1'b0);
      until_v(3, 1'b0, n);
      rs = ((i == 2) ? f - ex : r) * p * BASE_SER_CYC;
      if (i == 3) begin
        cmp_rng(g, 8, 12);
        cmp_rng(g + n, 32, 40);
      end else begin
        cmp_rng(g, rs - 2, rs + 4);
        cmp_rng(n, ex * p * BASE_SER_CYC - 2, ex * p * BASE_SER_CYC + 4);
      end
    end
    // triggered master and slave, first trigger free, second after first-line flag
    for (int m = 1; m < 3; m++) begin
      cfg(6, 2, 4, 20, 20, 4);
      wr(ADDR_CTRL, ctrl(m, 0, CHOOSE_FIRST_LINE));
      repeat (40) @(posedge pclk);
      for (int k = 0; k < 2; k++) begin
        w = (m == 1) ? (k ? 50 : 26) : (k ? 25 : 40);
        fire <= 1'b1;
        width <= 16'(w);
        wait_stat <= k[0];
        @(posedge pclk);
        fire <= 1'b0;
        until_v(3, 1'b1, g);
        until_v(3, 1'b0, n);
        if (k == 0) cmp_rng(g, 4, 14);
        if (k == 1) cmp_rng(n, 20 * 4 - 10, 20 * 4 - 6);
        else if (m == 1) cmp_rng(n, 58, 64);
        else cmp_rng(n, w - 2, w + 3);
      end
    end
    // rolling shutter with padding rows and first-line flag
    rnd = lfsr(rnd);
    pd = 1 + rnd[1:0] % 3;
    er = rnd[4:2] % 5;
    cfg(er, 3, 4, 20, 2, 4);
    wr(ADDR_PADDING, pd);
    wr(ADDR_CTRL, ctrl(MODE_ROLL, 0, CHOOSE_FIRST_LINE));
    until_v(0, 1'b1, n);
    until_v(0, 1'b0, n);
    until_v(0, 1'b1, n);
    until_v(0, 1'b0, n);
    cmp(n, pd * 4);
    pr = row_addr;
    ps = stat;
    for (int i = 0; i < 120; i++) begin
      @(posedge pclk);
      if (sq[0] === 1'b1) cmp(sq[1], 1'b0);
      if (row_addr === pr) cmp(roll_reset_row, roll_exp(row_addr, er, 2 + pd));
      if (stat === 1'b1 && ps === 1'b1 && row_addr === pr) cmp(row_addr, 16'h0);
      pr = row_addr;
      ps = stat;
    end
    conclude();
  end
endmodule : testbench
